// [design/lof_cfg.svh]
// register map, field positions, reset values and sizes of the lvds output formatter
`ifndef LOF_CFG_SVH
`define LOF_CFG_SVH
// register indices; byte address is four times the index
`define LOF_IDX_MODE 8'h10
`define LOF_IDX_LINK 8'h18
`define LOF_IDX_LEVEL 8'h19
`define LOF_IDX_ROUTE 8'h1A
`define LOF_IDX_TRIM 8'h1B
`define LOF_IDX_STATUS 8'h1C
// reset values
`define LOF_RST_MODE 8'h3E
`define LOF_RST_LINK 8'h70
`define LOF_RST_LEVEL 8'h05
`define LOF_RST_ROUTE 8'h03
`define LOF_RST_TRIM 8'h00
// writable bits; the rest read as zero
`define LOF_MASK_MODE 8'hFF
`define LOF_MASK_LINK 8'hFF
`define LOF_MASK_LEVEL 8'h5F
`define LOF_MASK_ROUTE 8'h73
`define LOF_MASK_TRIM 8'h33
// fields of the mode register
`define LOF_MODE_LSB 5
`define LOF_MODE_DUAL_IN 2'h0
`define LOF_MODE_SINGLE_IN 2'h1
`define LOF_MODE_TWO_STREAM 2'h2
// fields of the link register
`define LOF_BIT_DE_INV 7
`define LOF_BIT_HS_INV 6
`define LOF_BIT_VS_INV 5
`define LOF_BIT_LINK_CFG 4
`define LOF_BIT_A_WIDE 3
`define LOF_BIT_B_WIDE 2
`define LOF_BIT_A_LOWFMT 1
`define LOF_BIT_B_LOWFMT 0
// fields of the level, trim and routing registers
`define LOF_BIT_A_LEVEL_SEL 6
`define LOF_BIT_B_LEVEL_SEL 4
`define LOF_A_SWING_LSB 2
`define LOF_B_SWING_LSB 0
`define LOF_A_TRIM_LSB 4
`define LOF_B_TRIM_LSB 0
`define LOF_BIT_SWAP 6
// pixel buffer
`define LOF_FIFO_DEPTH 8
`endif

// [design/lof_pkg.sv]
// types shared by the lvds output formatter
package lof_pkg;
	typedef struct packed {
		logic src;
		logic de;
		logic hs;
		logic vs;
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} lof_pix_t;

	typedef struct packed {
		logic [6:0] lane3;
		logic [6:0] lane2;
		logic [6:0] lane1;
		logic [6:0] lane0;
	} lof_word_t;

	typedef struct packed {
		logic first_out_level_select;
		logic second_out_level_select;
		logic [1:0] first_out_swing;
		logic [1:0] second_out_swing;
		logic [1:0] first_out_level_trim;
		logic [1:0] second_out_level_trim;
	} lof_level_t;

	typedef enum logic [1:0] {LINK_SINGLE, LINK_DUAL, LINK_PAIR} lof_link_t;
endpackage : lof_pkg

// [design/lof_formatter.sv]
// lvds output formatter: apb registers, pixel buffer, routing and lane packing
//
// Contract
// - enable_signal_inverted clear sends data-enable high on active pixels, set sends it low.
// - line_sync_inverted set (default) drives line sync low in sync intervals, clear drives it high.
// - frame_sync_inverted set (default) drives frame sync low in sync intervals, clear drives it high.
// - link bit clear with input mode 00 or 01 enables both outputs as one dual link.
// - link bit clear with input mode 10 runs the two outputs as two independent single links.
// - link bit set (default) enables output A alone as a single link and keeps B off.
// - first_out_wide_pixel clear gives 18 bits and a dead fourth lane on A, set gives 24 bits with it.
// - second_out_wide_pixel clear gives 18 bits and a dead fourth lane on B, set gives 24 bits with it.
// - first_out_low_bits_format clear puts the two top bits per colour on A's fourth lane, set the two low bits.
// - second_out_low_bits_format clear puts the two top bits on B's fourth lane, set the two low bits.
// - format set with wide clear drops the two low bits per colour and keeps the fourth lane dead.
// - pixel swap clear sends odd pixels to A and even to B, set sends odd to B and even to A.
// - in two-stream input mode pixel swap sends input stream A to output B and B to A.
// - input mode 00 is dual input, 01 single (default), 10 two streams, 11 reserved.
`timescale 1ns/1ps

module lof_fifo #(
	parameter int WIDTH = 28,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic push;
	logic pop;
	logic [AW:0] next_count;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			in_ready <= 1'b1;
		end else begin
			count <= next_count;
			in_ready <= (next_count != DEPTH[AW:0]);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule : lof_fifo

module lof_formatter
	import lof_pkg::*;
(
	// clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RESET_N,
	// apb slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [3:0] I_PSTRB,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	// incoming pixels
	input wire logic I_PIX_VALID,
	input wire lof_pix_t I_PIX,
	output logic O_PIX_READY,
	// serializer side
	input wire logic I_OUT_READY,
	output lof_word_t O_CHA_WORD,
	output lof_word_t O_CHB_WORD,
	output logic O_CHA_VALID,
	output logic O_CHB_VALID,
	output logic O_CHA_EN,
	output logic O_CHB_EN,
	output logic O_CHA_LANE3_EN,
	output logic O_CHB_LANE3_EN,
	output lof_level_t O_LEVEL
);
	`include "lof_cfg.svh"

	logic [7:0] reg_mode;
	logic [7:0] reg_link;
	logic [7:0] reg_level;
	logic [7:0] reg_route;
	logic [7:0] reg_trim;
	logic [7:0] idx;
	logic hit;
	logic wr_en;
	logic [7:0] rd_val;
	logic [1:0] in_mode;
	lof_link_t link_mode;
	logic swap;
	logic [2:0] inv;
	logic [1:0] wide;
	logic [1:0] lowfmt;
	logic [1:0] ch_en;
	logic fifo_valid;
	lof_pix_t fifo_pix;
	logic [3:0] fifo_count;
	logic pop;
	logic pend;
	lof_pix_t held;
	lof_pix_t ch_pix [2];
	logic [1:0] ch_fire;
	lof_word_t ch_word [2];
	lof_word_t out_word [2];
	logic [1:0] out_valid;
	logic [1:0] out_en;
	logic [1:0] out_lane3;

	// apb decode
	assign idx = I_PADDR[9:2];
	assign hit = (I_PADDR[11:10] == 2'h0) && (I_PADDR[1:0] == 2'h0) &&
		(idx == `LOF_IDX_MODE || idx == `LOF_IDX_LINK || idx == `LOF_IDX_LEVEL ||
		idx == `LOF_IDX_ROUTE || idx == `LOF_IDX_TRIM || idx == `LOF_IDX_STATUS);
	assign wr_en = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && hit && I_PSTRB[0];

	always_comb begin
		case (idx)
			`LOF_IDX_MODE: rd_val = reg_mode;
			`LOF_IDX_LINK: rd_val = reg_link;
			`LOF_IDX_LEVEL: rd_val = reg_level;
			`LOF_IDX_ROUTE: rd_val = reg_route;
			`LOF_IDX_TRIM: rd_val = reg_trim;
			`LOF_IDX_STATUS: rd_val = {pend, fifo_count, ch_en[1], ch_en[0], link_mode == LINK_DUAL};
			default: rd_val = 8'h00;
		endcase
	end

	// answer in the first access cycle
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_PREADY <= 1'b0;
			O_PRDATA <= 32'h0000_0000;
			O_PSLVERR <= 1'b0;
		end else begin
			O_PREADY <= I_PSEL && !I_PENABLE;
			if (I_PSEL && !I_PENABLE) begin
				O_PRDATA <= (hit && !I_PWRITE) ? {24'h00_0000, rd_val} : 32'h0000_0000;
				O_PSLVERR <= !hit;
			end
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			reg_mode <= `LOF_RST_MODE;
			reg_link <= `LOF_RST_LINK;
			reg_level <= `LOF_RST_LEVEL;
			reg_route <= `LOF_RST_ROUTE;
			reg_trim <= `LOF_RST_TRIM;
		end else if (wr_en) begin
			case (idx)
				`LOF_IDX_MODE: reg_mode <= I_PWDATA[7:0] & `LOF_MASK_MODE;
				`LOF_IDX_LINK: reg_link <= I_PWDATA[7:0] & `LOF_MASK_LINK;
				`LOF_IDX_LEVEL: reg_level <= I_PWDATA[7:0] & `LOF_MASK_LEVEL;
				`LOF_IDX_ROUTE: reg_route <= I_PWDATA[7:0] & `LOF_MASK_ROUTE;
				`LOF_IDX_TRIM: reg_trim <= I_PWDATA[7:0] & `LOF_MASK_TRIM;
				default: reg_mode <= reg_mode;
			endcase
		end
	end

	assign in_mode = reg_mode[`LOF_MODE_LSB+:2];
	assign swap = reg_route[`LOF_BIT_SWAP];
	assign inv = {reg_link[`LOF_BIT_DE_INV], reg_link[`LOF_BIT_HS_INV], reg_link[`LOF_BIT_VS_INV]};
	assign wide = {reg_link[`LOF_BIT_B_WIDE], reg_link[`LOF_BIT_A_WIDE]};
	assign lowfmt = {reg_link[`LOF_BIT_B_LOWFMT], reg_link[`LOF_BIT_A_LOWFMT]};

	always_comb begin
		if (reg_link[`LOF_BIT_LINK_CFG]) begin
			link_mode = LINK_SINGLE;
		end else if (in_mode == `LOF_MODE_DUAL_IN || in_mode == `LOF_MODE_SINGLE_IN) begin
			link_mode = LINK_DUAL;
		end else if (in_mode == `LOF_MODE_TWO_STREAM) begin
			link_mode = LINK_PAIR;
		end else begin
			link_mode = LINK_SINGLE;
		end
	end
	assign ch_en = {link_mode != LINK_SINGLE, 1'b1};

	lof_fifo #(
		.WIDTH($bits(lof_pix_t)),
		.DEPTH(`LOF_FIFO_DEPTH)
	) u_fifo (
		.clk(I_CORE_CLK),
		.rst_n(I_RESET_N),
		.in_valid(I_PIX_VALID),
		.in_ready(O_PIX_READY),
		.in_data(I_PIX),
		.out_valid(fifo_valid),
		.out_ready(I_OUT_READY),
		.out_data(fifo_pix),
		.count(fifo_count)
	);

	assign pop = fifo_valid && I_OUT_READY;

	// odd pixel waits for its even partner
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			pend <= 1'b0;
			held <= '0;
		end else if (link_mode != LINK_DUAL) begin
			pend <= 1'b0;
		end else if (pop) begin
			pend <= !pend;
			if (!pend) begin
				held <= fifo_pix;
			end
		end
	end

	always_comb begin
		ch_pix[0] = fifo_pix;
		ch_pix[1] = fifo_pix;
		ch_fire = 2'b00;
		case (link_mode)
			LINK_DUAL: begin
				ch_pix[0] = swap ? fifo_pix : held;
				ch_pix[1] = swap ? held : fifo_pix;
				ch_fire = {2{pop && pend}};
			end
			LINK_PAIR: begin
				ch_fire[0] = pop && (fifo_pix.src == swap);
				ch_fire[1] = pop && (fifo_pix.src != swap);
			end
			default: begin
				ch_fire[0] = pop;
			end
		endcase
	end

	function automatic lof_word_t lof_pack(lof_pix_t p, logic wide_b, logic low_b, logic [2:0] inv_b);
		logic [5:0] r6;
		logic [5:0] g6;
		logic [5:0] b6;
		logic [1:0] re;
		logic [1:0] ge;
		logic [1:0] be;
		lof_word_t w;
		// which bits ride the fourth lane
		if (low_b) begin
			r6 = p.red[7:2];
			g6 = p.green[7:2];
			b6 = p.blue[7:2];
			re = p.red[1:0];
			ge = p.green[1:0];
			be = p.blue[1:0];
		end else begin
			r6 = p.red[5:0];
			g6 = p.green[5:0];
			b6 = p.blue[5:0];
			re = p.red[7:6];
			ge = p.green[7:6];
			be = p.blue[7:6];
		end
		w.lane0 = {g6[0], r6};
		w.lane1 = {b6[1:0], g6[5:1]};
		w.lane2 = {b6[5:2], p.vs ^ inv_b[0], p.hs ^ inv_b[1], p.de ^ inv_b[2]};
		w.lane3 = wide_b ? {1'b0, be, ge, re} : 7'h00;
		return w;
	endfunction : lof_pack

	generate
		for (genvar c = 0; c < 2; c++) begin : g_ch
			assign ch_word[c] = lof_pack(ch_pix[c], wide[c], lowfmt[c], inv);
			always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
				if (!I_RESET_N) begin
					out_word[c] <= '0;
					out_valid[c] <= 1'b0;
					out_en[c] <= 1'b0;
					out_lane3[c] <= 1'b0;
				end else begin
					out_en[c] <= ch_en[c];
					out_lane3[c] <= ch_en[c] && wide[c];
					out_valid[c] <= ch_en[c] && ch_fire[c];
					if (!ch_en[c]) begin
						out_word[c] <= '0;
					end else if (ch_fire[c]) begin
						out_word[c] <= ch_word[c];
					end
				end
			end
		end
	endgenerate

	assign O_CHA_WORD = out_word[0];
	assign O_CHB_WORD = out_word[1];
	assign O_CHA_VALID = out_valid[0];
	assign O_CHB_VALID = out_valid[1];
	assign O_CHA_EN = out_en[0];
	assign O_CHB_EN = out_en[1];
	assign O_CHA_LANE3_EN = out_lane3[0];
	assign O_CHB_LANE3_EN = out_lane3[1];

	// analog level fields passed to the output drivers
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_LEVEL <= '0;
		end else begin
			O_LEVEL.first_out_level_select <= reg_level[`LOF_BIT_A_LEVEL_SEL];
			O_LEVEL.second_out_level_select <= reg_level[`LOF_BIT_B_LEVEL_SEL];
			O_LEVEL.first_out_swing <= reg_level[`LOF_A_SWING_LSB+:2];
			O_LEVEL.second_out_swing <= reg_level[`LOF_B_SWING_LSB+:2];
			O_LEVEL.first_out_level_trim <= reg_trim[`LOF_A_TRIM_LSB+:2];
			O_LEVEL.second_out_level_trim <= reg_trim[`LOF_B_TRIM_LSB+:2];
		end
	end

	property p_de_pol;
		@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
		ch_fire[0] |=> O_CHA_WORD.lane2[0] == ($past(ch_pix[0].de) ^ $past(reg_link[`LOF_BIT_DE_INV]));
	endproperty
	a_de_pol: assert property (p_de_pol) else $error("data-enable polarity wrong");

	property p_hs_pol;
		@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
		ch_fire[0] |=> O_CHA_WORD.lane2[1] == ($past(ch_pix[0].hs) ^ $past(reg_link[`LOF_BIT_HS_INV]));
	endproperty
	a_hs_pol: assert property (p_hs_pol) else $error("line sync polarity wrong");

	property p_vs_pol;
		@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
		ch_fire[0] |=> O_CHA_WORD.lane2[2] == ($past(ch_pix[0].vs) ^ $past(reg_link[`LOF_BIT_VS_INV]));
	endproperty
	a_vs_pol: assert property (p_vs_pol) else $error("frame sync polarity wrong");

	property p_dual;
		@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
		(!reg_link[`LOF_BIT_LINK_CFG] && !in_mode[1]) |=> (O_CHA_EN && O_CHB_EN && O_CHA_VALID == O_CHB_VALID);
	endproperty
	a_dual: assert property (p_dual) else $error("dual link not paired");

	property p_pair;
		@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
		(link_mode == LINK_PAIR && pop) |=> (O_CHA_VALID != O_CHB_VALID) && O_CHB_EN;
	endproperty
	a_pair: assert property (p_pair) else $error("two single links not independent");

	property p_single;
		@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
		reg_link[`LOF_BIT_LINK_CFG] ##1 reg_link[`LOF_BIT_LINK_CFG] |=> (O_CHA_EN && !O_CHB_EN && !O_CHB_VALID);
	endproperty
	a_single: assert property (p_single) else $error("second output active in single link");

	property p_lane3;
		@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
		1'b1 |=> O_CHA_LANE3_EN == $past(wide[0]) && O_CHB_LANE3_EN == ($past(wide[1]) && O_CHB_EN);
	endproperty
	a_lane3: assert property (p_lane3) else $error("fourth lane enable wrong");

	property p_trunc;
		@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
		(ch_fire[0] && lowfmt[0] && !wide[0]) |=>
		O_CHA_WORD.lane0[5:0] == $past(ch_pix[0].red[7:2]) && O_CHA_WORD.lane3 == 7'h00;
	endproperty
	a_trunc: assert property (p_trunc) else $error("24 to 18 bit reduction wrong");

	property p_swap;
		@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
		(link_mode == LINK_DUAL && pop && pend && !swap) |=>
		O_CHB_WORD.lane0[5:0] == $past(fifo_pix.red[5:0]) || $past(lowfmt[1]);
	endproperty
	a_swap: assert property (p_swap) else $error("even pixel not on second output");

	property p_quiet;
		@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
		(!O_CHB_EN ##1 !O_CHB_EN) |-> O_CHB_WORD == '0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("disabled output not quiet");

	property p_fmt_a;
		@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
		(ch_fire[0] && wide[0] && !lowfmt[0]) |=> O_CHA_WORD.lane3 ==
		{1'b0, $past(ch_pix[0].blue[7:6]), $past(ch_pix[0].green[7:6]), $past(ch_pix[0].red[7:6])};
	endproperty
	a_fmt_a: assert property (p_fmt_a) else $error("first output fourth lane format wrong");

	property p_fmt_b;
		@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
		(ch_fire[1] && wide[1] && !lowfmt[1]) |=> O_CHB_WORD.lane3 ==
		{1'b0, $past(ch_pix[1].blue[7:6]), $past(ch_pix[1].green[7:6]), $past(ch_pix[1].red[7:6])};
	endproperty
	a_fmt_b: assert property (p_fmt_b) else $error("second output fourth lane format wrong");

	property p_pair_route;
		@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
		(link_mode == LINK_PAIR && pop) |=> O_CHB_VALID == ($past(fifo_pix.src) ^ $past(swap));
	endproperty
	a_pair_route: assert property (p_pair_route) else $error("stream routed to wrong output");

	property p_reserved;
		@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
		(in_mode == 2'h3 && pop) |=> O_CHA_VALID && !O_CHB_VALID;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved input mode not on first output");

	property p_apb;
		@(posedge I_CORE_CLK) disable iff (!I_RESET_N)
		(I_PSEL && !I_PENABLE) |=> O_PREADY ##1 !O_PREADY;
	endproperty
	a_apb: assert property (p_apb) else $error("apb answer timing wrong");

	c_dual: cover property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N) link_mode == LINK_DUAL && O_CHB_VALID);
	c_pair: cover property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N) link_mode == LINK_PAIR && O_CHB_VALID);
	c_full: cover property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N) !O_PIX_READY);
	c_wide: cover property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N) O_CHA_VALID && O_CHA_LANE3_EN);
	c_swap: cover property (@(posedge I_CORE_CLK) disable iff (!I_RESET_N) link_mode == LINK_DUAL && swap && O_CHA_VALID);
endmodule : lof_formatter

// [dv/lof_panel.sv]
// far-side panel model: flow control and capture of emitted words
`timescale 1ns/1ps
module lof_panel
	import lof_pkg::*;
(
	// clock, reset and stall control
	input wire logic clk,
	input wire logic rst_n,
	input wire logic stall,
	// words from the formatter
	input wire lof_word_t cha_word,
	input wire lof_word_t chb_word,
	input wire logic cha_valid,
	input wire logic chb_valid,
	// flow control and capture
	output logic ready,
	output lof_word_t last_a,
	output lof_word_t last_b,
	output logic [15:0] cnt_a,
	output logic [15:0] cnt_b
);
	assign ready = ~stall;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_a <= 16'h0000;
			cnt_b <= 16'h0000;
			last_a <= '0;
			last_b <= '0;
		end else begin
			if (cha_valid) begin
				cnt_a <= cnt_a + 16'h0001;
				last_a <= cha_word;
			end
			if (chb_valid) begin
				cnt_b <= cnt_b + 16'h0001;
				last_b <= chb_word;
			end
		end
	end
endmodule : lof_panel

// [dv/tb.sv]
// testbench of the lvds output formatter: apb tasks, pixel traffic and expected words
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb import lof_pkg::*;;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pix_valid = 1'b0, stall = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, pix_ready, out_ready, cha_v, chb_v, cha_en, chb_en, a3_en, b3_en;
	lof_pix_t pix = '0, pa, pb;
	lof_word_t wa, wb, last_a, last_b;
	lof_level_t lvl;
	logic [15:0] cnt_a, cnt_b;
	logic [7:0] lnk = 8'h70;
	int bad_count = 0, cmp_count = 0, k, ea, eb;

	always #4 clk = ~clk;

	lof_formatter u_lof_formatter (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'hF), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_PIX_VALID(pix_valid), .I_PIX(pix), .O_PIX_READY(pix_ready),
		.I_OUT_READY(out_ready), .O_CHA_WORD(wa), .O_CHB_WORD(wb), .O_CHA_VALID(cha_v), .O_CHB_VALID(chb_v),
		.O_CHA_EN(cha_en), .O_CHB_EN(chb_en), .O_CHA_LANE3_EN(a3_en), .O_CHB_LANE3_EN(b3_en), .O_LEVEL(lvl));
	lof_panel u_lof_panel (.clk(clk), .rst_n(rst_n), .stall(stall), .cha_word(wa), .chb_word(wb),
		.cha_valid(cha_v), .chb_valid(chb_v), .ready(out_ready), .last_a(last_a), .last_b(last_b),
		.cnt_a(cnt_a), .cnt_b(cnt_b));

	task results;
		$display("compares=%0d mismatches=%0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results

	task guard(input logic ok);
		if (ok !== 1'b1) begin
			bad_count++;
			results();
		end
	endtask : guard

	task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		guard(pready);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rdchk(input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		`CHK(rd, {24'h000000, e})
	endtask : rdchk

	task push(input lof_pix_t p);
		int n;
		@(posedge clk);
		pix_valid <= 1'b1;
		pix <= p;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pix_ready !== 1'b1 && n < 50);
		guard(pix_ready);
		pix_valid <= 1'b0;
	endtask : push

	task wait_out(input int a, input int b);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!(cnt_a == a && cnt_b == b) && n < 40);
		guard(cnt_a == a && cnt_b == b);
	endtask : wait_out

	function automatic lof_pix_t mk(input logic s, input logic [7:0] v);
		return {s, 1'b1, v[0], v[1], 8'hA5 ^ v, 8'h3C + v, 8'hC3 ^ v};
	endfunction : mk

	// expected lane packing of one pixel for channel b (0 = first output)
	function automatic lof_word_t ew(input lof_pix_t p, input logic b);
		logic wide, low;
		logic [5:0] r6, g6, b6;
		lof_word_t w;
		wide = b ? lnk[2] : lnk[3];
		low = b ? lnk[0] : lnk[1];
		r6 = low ? p.red[7:2] : p.red[5:0];
		g6 = low ? p.green[7:2] : p.green[5:0];
		b6 = low ? p.blue[7:2] : p.blue[5:0];
		w.lane0 = {g6[0], r6};
		w.lane1 = {b6[1:0], g6[5:1]};
		w.lane2 = {b6[5:2], p.vs ^ lnk[5], p.hs ^ lnk[6], p.de ^ lnk[7]};
		w.lane3 = 7'h00;
		if (wide) w.lane3 = low ? {1'b0, p.blue[1:0], p.green[1:0], p.red[1:0]} :
			{1'b0, p.blue[7:6], p.green[7:6], p.red[7:6]};
		return w;
	endfunction : ew

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rdchk(12'h040, 8'h3E);
		rdchk(12'h060, 8'h70);
		rdchk(12'h064, 8'h05);
		rdchk(12'h068, 8'h03);
		rdchk(12'h070, 8'h02);
		rdchk(12'h07C, 8'h00);
		`CHK(err, 1'b1)
		`CHK({cha_en, chb_en, a3_en}, 3'b100)
		// buffer filled with the panel stalled, then drained
		stall <= 1'b1;
		@(posedge clk);
		pix_valid <= 1'b1;
		pix <= mk(1'b0, 8'h11);
		k = 0;
		while (k < 20) begin
			@(negedge clk);
			if (pix_ready !== 1'b1) break;
			k++;
			@(posedge clk);
		end
		`CHK(k, 8)
		@(posedge clk);
		pix_valid <= 1'b0;
		stall <= 1'b0;
		wait_out(8, 0);
		`CHK(last_a, ew(mk(1'b0, 8'h11), 1'b0))
		`CHK(wb, 28'h0)
		// single link: polarity, width and format combinations
		for (int i = 0; i < 4; i++) begin
			lnk = {i[0], ~i[0], i[1], 1'b1, i[1], 1'b0, i[0], 1'b0};
			wr(12'h060, lnk);
			push(mk(1'b0, i[7:0] ^ 8'h5A));
			wait_out(9 + i, 0);
			`CHK(last_a, ew(mk(1'b0, i[7:0] ^ 8'h5A), 1'b0))
			`CHK(a3_en, lnk[3])
		end
		// dual link, odd and even pairing with and without swap
		for (int i = 0; i < 2; i++) begin
			lnk = {7'h02, i[0]};
			wr(12'h040, i[0] ? 8'h3E : 8'h1E);
			wr(12'h060, lnk);
			wr(12'h068, {1'b0, i[0], 6'h00});
			pa = mk(1'b0, {7'h20, i[0]});
			pb = mk(1'b0, {7'h30, i[0]});
			push(pa);
			push(pb);
			wait_out(13 + i, 1 + i);
			`CHK(last_a, ew(i[0] ? pb : pa, 1'b0))
			`CHK(last_b, ew(i[0] ? pa : pb, 1'b1))
			`CHK({cha_en, chb_en, b3_en}, 3'b111)
		end
		// two independent streams, routed by source and swap
		wr(12'h040, 8'h5E);
		lnk = 8'h00;
		wr(12'h060, lnk);
		ea = 14;
		eb = 2;
		for (int i = 0; i < 4; i++) begin
			wr(12'h068, {1'b0, i[1], 6'h00});
			pa = mk(i[0], i[7:0] ^ 8'h66);
			push(pa);
			if (i[0] ^ i[1]) eb++;
			else ea++;
			wait_out(ea, eb);
			`CHK((i[0] ^ i[1]) ? last_b : last_a, ew(pa, i[0] ^ i[1]))
			`CHK({cha_en, chb_en}, 2'b11)
		end
		// reserved input mode falls back to one link
		wr(12'h040, 8'h7E);
		push(mk(1'b1, 8'h77));
		wait_out(ea + 1, eb);
		`CHK(chb_en, 1'b0)
		`CHK(last_a, ew(mk(1'b1, 8'h77), 1'b0))
		// trim before low level, then level outputs
		wr(12'h06C, 8'h11);
		wr(12'h064, 8'h55);
		rdchk(12'h064, 8'h55);
		`CHK(lvl, 10'b1101010101)
		results();
	end
endmodule : tb
